// *** core/dpd_debug_probe_detect.sv ***
// Added by the designer: register access over AXI4-Lite and the register addresses.
`default_nettype none
module dpd_debug_probe_detect (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic por_n,
	input wire logic ext_reset_n,
	input wire logic swclk_pad,
	input wire logic reset_ext_req,
	input wire logic [1:0] debug_access_level,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic hot_plug_avail_flag,
	output logic probe_present_flag,
	output dpd_pkg::dpd_access_type mem_access,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers: three stages, a change counts when stages two and three agree.
	logic [2:0] s_por, s_ext, s_clk, s_req;
	logic por_q, ext_q, clk_q, req_q;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_por <= 3'h0;
			s_ext <= 3'h0;
			s_clk <= 3'h7;
			s_req <= 3'h0;
		end else begin
			s_por <= {s_por[1:0], por_n};
			s_ext <= {s_ext[1:0], ext_reset_n};
			s_clk <= {s_clk[1:0], swclk_pad};
			s_req <= {s_req[1:0], reset_ext_req};
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			por_q <= 1'b0;
			ext_q <= 1'b0;
			clk_q <= 1'b1;
			req_q <= 1'b0;
		end else begin
			if (s_por[1] == s_por[2]) por_q <= s_por[2];
			if (s_ext[1] == s_ext[2]) ext_q <= s_ext[2];
			if (s_clk[1] == s_clk[2]) clk_q <= s_clk[2];
			if (s_req[1] == s_req[2]) req_q <= s_req[2];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Detection.
	logic sys_reset, clk_fall, pad_moved, cold_ev, hot_ev, swclk_fn_debug;
	logic wr_fire;
	logic [31:0] wr_data;
	logic [11:0] wr_addr;
	assign sys_reset = !por_q || !ext_q;
	assign clk_fall = (s_clk[1] == s_clk[2]) && clk_q && !s_clk[2];
	// Pads are unpowered until power-on reset lifts, so nothing is seen before then.
	assign cold_ev = por_q && !ext_q && req_q;
	assign hot_ev = !sys_reset && hot_plug_avail_flag && clk_fall;

	always_ff @(posedge clk_sys) begin
		if (rst || sys_reset) begin
			pad_moved <= 1'b0;
		end else if (!swclk_fn_debug) begin
			pad_moved <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || sys_reset) begin
			hot_plug_avail_flag <= 1'b0;
		end else begin
			hot_plug_avail_flag <= swclk_fn_debug && !pad_moved &&
				(debug_access_level != dpd_pkg::dal_none);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || !por_q) begin
			probe_present_flag <= 1'b0;
		end else if (cold_ev || hot_ev) begin
			probe_present_flag <= 1'b1;
		end else if (!ext_q && !req_q) begin
			// External reset clears the flag unless a cold plug holds it.
			probe_present_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mem_access <= '0;
		end else begin
			mem_access.secure_ok <= probe_present_flag &&
				(debug_access_level == dpd_pkg::dal_full);
			mem_access.nonsecure_ok <= probe_present_flag &&
				(debug_access_level == dpd_pkg::dal_full ||
				debug_access_level == dpd_pkg::dal_nonsecure);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control, sticky event bits and interrupt.
	logic [1:0] irq_status, irq_mask;
	logic rd_fire, rd_status;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			swclk_fn_debug <= 1'b1;
		end else if (wr_fire && wr_addr == dpd_pkg::control_offset) begin
			swclk_fn_debug <= wr_data[0];
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_mask <= dpd_pkg::irq_mask_reset;
		end else if (wr_fire && wr_addr == dpd_pkg::irq_mask_offset) begin
			// The mask shares the status layout, so its bits sit at the event positions.
			irq_mask <= {wr_data[dpd_pkg::hot_bit], wr_data[dpd_pkg::cold_bit]};
		end
	end
	assign rd_status = rd_fire && s_axi_araddr == dpd_pkg::irq_status_offset;
	// A new event in the clearing read's cycle survives it.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_status <= 2'h0;
		end else begin
			irq_status <= (rd_status ? 2'h0 : irq_status) | {hot_ev, cold_ev};
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) irq <= 1'b0;
		else irq <= |(irq_status & irq_mask);
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave; address and data are latched in either order.
	logic aw_held, w_held;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= 12'h000;
			wr_data <= 32'h0000_0000;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= dpd_pkg::axi_okay;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				wr_addr <= {s_axi_awaddr[11:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				wr_data <= s_axi_wdata;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_addr == dpd_pkg::control_offset ||
					wr_addr == dpd_pkg::irq_mask_offset) ? dpd_pkg::axi_okay : dpd_pkg::axi_slverr;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign rd_fire = s_axi_arvalid && s_axi_arready;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= dpd_pkg::axi_okay;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= dpd_pkg::axi_okay;
				s_axi_rdata <= 32'h0000_0000;
				unique case ({s_axi_araddr[11:2], 2'b00})
					dpd_pkg::status_reg_b_offset: begin
						s_axi_rdata[dpd_pkg::avail_bit] <= hot_plug_avail_flag;
						s_axi_rdata[dpd_pkg::present_bit] <= probe_present_flag;
						s_axi_rdata[dpd_pkg::pad_moved_bit] <= pad_moved;
					end
					dpd_pkg::control_offset: s_axi_rdata[0] <= swclk_fn_debug;
					dpd_pkg::irq_status_offset: begin
						s_axi_rdata[dpd_pkg::cold_bit] <= irq_status[0];
						s_axi_rdata[dpd_pkg::hot_bit] <= irq_status[1];
					end
					dpd_pkg::irq_mask_offset: begin
						s_axi_rdata[dpd_pkg::cold_bit] <= irq_mask[0];
						s_axi_rdata[dpd_pkg::hot_bit] <= irq_mask[1];
					end
					default: s_axi_rresp <= dpd_pkg::axi_slverr;
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : dpd_debug_probe_detect
`default_nettype wire

// *** core/dpd_pkg.sv ***
// Functional notes
// - Reset-extension request during reset: cold-plug detected.
// - Hot-plug detector held reset during system reset.
// - Serial clock falling edge flags hot-plug.
// - Pad reassignment disables hot-plug until reset.
// - Hot-plug availability flag readable in status.
// - Either detection sets probe-present flag.
// - Access level zero disables hot-plug detection.
// - No detection before power-on reset release.
// - Access level two: secure and non-secure access.
// - Access level one: non-secure access only.
`default_nettype none
package dpd_pkg;
	localparam logic [11:0] status_reg_b_offset = 12'h000;
	localparam logic [11:0] control_offset = 12'h004;
	localparam logic [11:0] irq_status_offset = 12'h008;
	localparam logic [11:0] irq_mask_offset = 12'h00c;
	localparam int avail_bit = 0;
	localparam int present_bit = 1;
	localparam int cold_bit = 2;
	localparam int hot_bit = 3;
	localparam int pad_moved_bit = 4;
	localparam logic [1:0] dal_none = 2'h0;
	localparam logic [1:0] dal_nonsecure = 2'h1;
	localparam logic [1:0] dal_full = 2'h2;
	localparam logic [1:0] dal_reset = 2'h2;
	localparam logic [1:0] irq_mask_reset = 2'h0;
	localparam logic [1:0] axi_okay = 2'h0;
	localparam logic [1:0] axi_slverr = 2'h2;

	typedef struct packed {
		logic secure_ok;
		logic nonsecure_ok;
	} dpd_access_type;
endpackage : dpd_pkg
`default_nettype wire

// *** verif/dpd_probe_monitor.sv ***
`default_nettype none
module dpd_probe_monitor (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic por_n,
	input wire logic ext_reset_n,
	input wire logic swclk_pad,
	input wire logic reset_ext_req,
	input wire logic [1:0] debug_access_level,
	input wire logic hot_plug_avail_flag,
	input wire logic probe_present_flag,
	input wire dpd_pkg::dpd_access_type mem_access
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Raw pins are watched here, so each window leaves room for the design's synchronisers.
	sequence sys_run; (por_n && ext_reset_n)[*8]; endsequence
	sequence hot_edge; $fell(swclk_pad) && hot_plug_avail_flag; endsequence
	sequence cold_req; (por_n && !ext_reset_n && reset_ext_req)[*8]; endsequence
	a_cold_detect: assert property (cold_req |-> ##[0:8] probe_present_flag)
		else $error("cold plug missed");
	a_hot_detect: assert property (hot_edge ##1 sys_run |-> probe_present_flag)
		else $error("hot plug missed");
	a_reset_no_avail: assert property ((!por_n || !ext_reset_n)[*8] |-> !hot_plug_avail_flag)
		else $error("avail in reset");
	a_ext_clear: assert property ((!ext_reset_n && !reset_ext_req)[*8] |-> !probe_present_flag)
		else $error("present kept");
	a_level_zero: assert property (debug_access_level == 2'h0 |=> !hot_plug_avail_flag)
		else $error("avail at level 0");
	a_secure_lvl: assert property (mem_access.secure_ok |-> $past(debug_access_level) == 2'h2)
		else $error("secure grant");
	a_nonsec_lvl: assert property (mem_access.nonsecure_ok |-> $past(debug_access_level) != 2'h0)
		else $error("nonsecure grant");
	a_present_sticky: assert property (sys_run ##0 probe_present_flag |=> probe_present_flag)
		else $error("present dropped");
endmodule : dpd_probe_monitor
bind dpd_debug_probe_detect dpd_probe_monitor dpd_probe_monitor_inst (.*);
`default_nettype wire

// *** verif/dpd_probe_model.sv ***
`default_nettype none
module dpd_probe_model (
	input wire logic run,
	input wire logic req,
	output logic swclk_pad,
	output logic reset_ext_req
);
	timeunit 1ns;
	timeprecision 100ps;
	// The probe parks its clock high between frames, off phase with the system clock.
	initial begin
		swclk_pad = 1'h1;
		#7;
		forever #32 swclk_pad = run ? ~swclk_pad : 1'h1;
	end
	assign reset_ext_req = req;
endmodule : dpd_probe_model
`default_nettype wire

// *** verif/dpd_debug_probe_detect_tb_top.sv ***
`default_nettype none
module dpd_debug_probe_detect_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'h0, rst = 1'h1, por_n = 1'h0, ext_reset_n = 1'h0, run = 1'h0, req = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [1:0] debug_access_level = 2'h2;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	// Strobes are tied: the block only takes whole words.
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic hot_plug_avail_flag, probe_present_flag, irq, swclk_pad, reset_ext_req;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	dpd_pkg::dpd_access_type mem_access;
	int n_fail = 0, cmp_count = 0;
	dpd_debug_probe_detect dpd_debug_probe_detect_inst (.*);
	dpd_probe_model dpd_probe_model_inst (.run, .req, .swclk_pad, .reset_ext_req);
	always #2.5 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", n, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int t = 0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			t++;
		end while (s_axi_bvalid !== 1'h1 && t < 50);
		s_axi_bready <= 1'h0;
		chk("bvalid", 32'(s_axi_bvalid), 32'h1);
		chk("bresp", 32'(s_axi_bresp), 32'h0);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		int t = 0;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			t++;
		end while (s_axi_rvalid !== 1'h1 && t < 50);
		s_axi_rready <= 1'h0;
		chk("rvalid", 32'(s_axi_rvalid), 32'h1);
		chk("rdata", s_axi_rdata, e);
		chk("rresp", 32'(s_axi_rresp), 32'(er));
	endtask : rd
	task automatic sys_reset;
		@(posedge clk_sys);
		ext_reset_n <= 1'h0;
		cyc(20);
		ext_reset_n <= 1'h1;
		cyc(20);
	endtask : sys_reset
	task automatic frame;
		run <= 1'h1;
		cyc(40);
		run <= 1'h0;
		cyc(10);
	endtask : frame
	task final_report;
		if (n_fail == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////
	initial begin
		#20000;
		n_fail++;
		final_report;
	end
	initial begin
		cyc(5);
		rst <= 1'h0;
		req <= 1'h1;
		cyc(20);
		chk("present", 32'(probe_present_flag), 32'h0);
		por_n <= 1'h1;
		cyc(20);
		chk("present", 32'(probe_present_flag), 32'h1);
		chk("avail", 32'(hot_plug_avail_flag), 32'h0);
		rd(dpd_pkg::irq_status_offset, 32'h4, dpd_pkg::axi_okay);
		ext_reset_n <= 1'h1;
		req <= 1'h0;
		cyc(20);
		// The cold event stood until release, so its sticky bit is set again and this read clears it.
		rd(dpd_pkg::irq_status_offset, 32'h4, dpd_pkg::axi_okay);
		rd(dpd_pkg::status_reg_b_offset, 32'h3, dpd_pkg::axi_okay);
		rd(dpd_pkg::control_offset, 32'h1, dpd_pkg::axi_okay);
		rd(12'h010, 32'h0, dpd_pkg::axi_slverr);
		chk("access", 32'(mem_access), 32'h3);
		debug_access_level <= dpd_pkg::dal_nonsecure;
		cyc(5);
		chk("access", 32'(mem_access), 32'h1);
		sys_reset;
		chk("present", 32'(probe_present_flag), 32'h0);
		wr(dpd_pkg::irq_mask_offset, 32'h8);
		frame;
		chk("present", 32'(probe_present_flag), 32'h1);
		chk("irq", 32'(irq), 32'h1);
		rd(dpd_pkg::irq_status_offset, 32'h8, dpd_pkg::axi_okay);
		cyc(3);
		chk("irq", 32'(irq), 32'h0);
		sys_reset;
		debug_access_level <= dpd_pkg::dal_none;
		cyc(3);
		chk("avail", 32'(hot_plug_avail_flag), 32'h0);
		frame;
		chk("present", 32'(probe_present_flag), 32'h0);
		debug_access_level <= dpd_pkg::dal_full;
		wr(dpd_pkg::control_offset, 32'h0);
		cyc(3);
		rd(dpd_pkg::status_reg_b_offset, 32'h10, dpd_pkg::axi_okay);
		frame;
		chk("present", 32'(probe_present_flag), 32'h0);
		wr(dpd_pkg::control_offset, 32'h1);
		cyc(3);
		chk("avail", 32'(hot_plug_avail_flag), 32'h0);
		sys_reset;
		chk("avail", 32'(hot_plug_avail_flag), 32'h1);
		final_report;
	end
endmodule : dpd_debug_probe_detect_tb_top
`default_nettype wire
